// File: verilog/adc_host.sv
// host controller for a serial 12-bit converter: framing, power mode, read-out
`timescale 1ns/1ps
module adc_host
  import adc_host_pkg::*;
#(
  parameter int QUIET_CYC = QUIET_GAP_CYC,
  parameter int IDLE_CYC  = IDLE_CYC_MIN,
  parameter int PWR_CYC   = POWERUP_CYC
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // user control
  input  wire logic        conv_req,
  input  wire logic        low_power,
  output logic             conv_ready,
  // user result
  output logic [11:0]      result,
  output logic             result_valid,
  output logic             powered_down,
  // converter pins
  output logic             frame_sel_n,
  output logic             shift_clk,
  input  wire logic        serial_result_out
);
  import adc_host_pkg::*;

  shift_link_if lnk ();

  adc_shift_engine u_eng
  (
    .clk               (clk),
    .rst               (rst),
    .lnk               (lnk),
    .frame_sel_n       (frame_sel_n),
    .shift_clk         (shift_clk),
    .serial_result_out (serial_result_out)
  );

  //----------------------------------------------------------------------------
  // sequencer state
  //----------------------------------------------------------------------------
  host_state_t st_ff;
  host_state_t nxt_st;
  logic [9:0]  gap_ff;
  logic [9:0]  nxt_gap;
  logic        dummy_ff;      // next completed word must be thrown away
  logic        nxt_dummy;
  logic        asleep_ff;
  logic        nxt_asleep;
  logic        cut_ff;        // current frame is a shutdown frame
  logic        nxt_cut;
  logic [11:0] res_ff;
  logic [11:0] nxt_res;
  logic        vld_ff;
  logic        nxt_vld;
  logic [9:0]  wait_need;

  // gap is the longest of the quiet gap, the rate-limit idle and, while asleep after a shutdown frame, the power-up time
  always_comb
  begin
    wait_need = 10'(QUIET_CYC);
    if (10'(IDLE_CYC) > wait_need)
      wait_need = 10'(IDLE_CYC);
    if (asleep_ff && 10'(PWR_CYC) > wait_need)
      wait_need = 10'(PWR_CYC);
  end

  // frame scheduling, dummy tracking and result capture
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_gap    = gap_ff;
    nxt_dummy  = dummy_ff;
    nxt_asleep = asleep_ff;
    nxt_cut    = cut_ff;
    nxt_res    = res_ff;
    nxt_vld    = 1'b0;
    case (st_ff)
      ST_IDLE:
      begin
        if (low_power && !asleep_ff)
        begin
          nxt_cut = 1'b1; // short frame puts device to sleep
          nxt_st  = ST_CUT;
        end
        else if (conv_req)
        begin
          nxt_cut = 1'b0;
          nxt_st  = ST_SHIFT;
        end
      end
      ST_SHIFT, ST_CUT:
      begin
        if (lnk.done)
        begin
          nxt_gap = 10'h000;
          nxt_st  = ST_GAP;
          if (cut_ff)
            nxt_asleep = 1'b1; // stays down until next frame
          else
          begin
            // a frame from sleep or power-on is a dummy
            if (!dummy_ff)
            begin
              nxt_res = lnk.word[11:0]; // bit 12 absorbs the extra zero
              nxt_vld = 1'b1;
            end
            nxt_dummy  = 1'b0;
            nxt_asleep = 1'b0; // full power after sixteen clocks
          end
        end
      end
      ST_GAP:
      begin
        if (gap_ff >= wait_need)
          nxt_st = ST_IDLE;
        else
          nxt_gap = gap_ff + 10'h001;
      end
      default:
        nxt_st = ST_IDLE;
    endcase
    if (nxt_asleep && !asleep_ff)
      nxt_dummy = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff     <= ST_IDLE;
      gap_ff    <= 10'h000;
      dummy_ff  <= 1'b1; // mode unknown at power-on
      asleep_ff <= 1'b0;
      cut_ff    <= 1'b0;
      res_ff    <= RESULT_RST;
      vld_ff    <= 1'b0;
    end
    else
    begin
      st_ff     <= nxt_st;
      gap_ff    <= nxt_gap;
      dummy_ff  <= nxt_dummy;
      asleep_ff <= nxt_asleep;
      cut_ff    <= nxt_cut;
      res_ff    <= nxt_res;
      vld_ff    <= nxt_vld;
    end
  end

  // engine start is a pulse on leaving idle; frame-select always returns high
  assign lnk.start     = (st_ff == ST_IDLE) && (nxt_st != ST_IDLE);
  assign lnk.clk_limit = (nxt_st == ST_CUT || st_ff == ST_CUT) ?
                         5'(SD_CUT_CLKS) : 5'(FRAME_CLKS);
  assign conv_ready    = (st_ff == ST_IDLE) && !low_power;
  assign result        = res_ff;
  assign result_valid  = vld_ff;
  assign powered_down  = asleep_ff;

  //----------------------------------------------------------------------------
  // pin watchers for the checks below
  //----------------------------------------------------------------------------
  // counted from the pins, apart from the engine's own counters, so that a
  // slip in the engine cannot hide behind its own numbers
  logic        sck_seen_ff;
  logic        nxt_sck_seen;
  logic        fsel_seen_ff;
  logic        nxt_fsel_seen;
  logic [4:0]  rise_ff;       // rising shift clocks in this frame
  logic [4:0]  nxt_rise;
  logic [7:0]  period_ff;     // clocks since frame-select last fell, saturating
  logic [7:0]  nxt_period;
  logic        full_ff;       // last frame gave all sixteen clocks
  logic        nxt_full;

  // edge memory, rise count per frame and frame-to-frame spacing
  always_comb
  begin
    nxt_sck_seen  = shift_clk;
    nxt_fsel_seen = frame_sel_n;
    nxt_rise      = rise_ff;
    nxt_period    = period_ff;
    nxt_full      = full_ff;
    if (frame_sel_n)
    begin
      nxt_rise = 5'h00;
      if (!fsel_seen_ff)
        nxt_full = (rise_ff == 5'(FRAME_CLKS));
    end
    else if (shift_clk && !sck_seen_ff)
      nxt_rise = rise_ff + 5'h01;
    if (fsel_seen_ff && !frame_sel_n)
      nxt_period = 8'h01;
    else if (period_ff != 8'hFF)
      nxt_period = period_ff + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sck_seen_ff  <= 1'b0;
      fsel_seen_ff <= 1'b1;
      rise_ff      <= 5'h00;
      period_ff    <= 8'hFF; // first frame after reset has no predecessor
      full_ff      <= 1'b0;
    end
    else
    begin
      sck_seen_ff  <= nxt_sck_seen;
      fsel_seen_ff <= nxt_fsel_seen;
      rise_ff      <= nxt_rise;
      period_ff    <= nxt_period;
      full_ff      <= nxt_full;
    end
  end

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  // no new frame while the quiet gap runs
  chk_quiet_gap : assert property (@(posedge clk) disable iff (rst)
    $rose(lnk.done) |-> ##1 (frame_sel_n [*3])) else $error("frame too soon");
  // dummy word never reported
  chk_dummy_drop : assert property (@(posedge clk) disable iff (rst)
    (lnk.done && dummy_ff) |=> !vld_ff) else $error("dummy result reported");
  // leading zeros of a full word are zero from a healthy device
  chk_lead_zero : assert property (@(posedge clk) disable iff (rst)
    (lnk.done && !cut_ff && !dummy_ff) |-> lnk.word[15:13] == 3'h0)
    else $error("leading bits not zero");
  // shutdown frame sets the sleep flag
  chk_sleep_set : assert property (@(posedge clk) disable iff (rst)
    (lnk.done && cut_ff && st_ff == ST_CUT) |=> asleep_ff)
    else $error("sleep not recorded");
  // a full frame wakes the device
  chk_wake : assert property (@(posedge clk) disable iff (rst)
    (lnk.done && st_ff == ST_SHIFT) |=> !asleep_ff) else $error("wake missed");
  // frames only start from idle, with the engine at rest
  chk_start_idle : assert property (@(posedge clk) disable iff (rst)
    lnk.start |-> (!lnk.busy && $past(frame_sel_n))) else $error("start inside frame");
  // every frame carries its full count of rising clocks, or the short count
  chk_rise_count : assert property (@(posedge clk) disable iff (rst)
    $rose(frame_sel_n) |-> rise_ff == (cut_ff ? 5'(SD_CUT_CLKS) : 5'(FRAME_CLKS)))
    else $error("shift clock count per frame wrong");
  // back-to-back full frames start no closer than the rate limit allows
  chk_frame_rate : assert property (@(posedge clk) disable iff (rst)
    ($fell(frame_sel_n) && full_ff) |-> period_ff >= 8'(RATE_DIV * 2 * SCLK_HALF_CYC))
    else $error("frames closer than rate limit");
endmodule

// File: verilog/adc_host_pkg.sv
// package of constants and types for the serial converter host controller
//------------------------------------------------------------------------------
// Functional notes
// - host waits quiet gap before next frame
// - host gives sixteen shift clocks per frame; shutdown frames here stop after two
// - device shifts on fall, host samples on rise
// - early frame fall may add one leading zero
// - frame-select idled low must rise before next frame
// - shutdown exit powers up; discard first result
// - host does one dummy conversion after power-on
// - quiet gap still follows the dummy conversion
// - continuous rate at most shift clock over 20
// - host may end frame between clock 10 and 15
//------------------------------------------------------------------------------
package adc_host_pkg;
  localparam int          SCLK_HALF_CYC   = 4;      // 25 MHz / 8 = 3.125 MHz shift clock
  localparam int          FRAME_CLKS      = 16;
  localparam int          SD_CUT_CLKS     = 2;      // frame ended after clock 2: shutdown
  localparam int          LEAD_ZEROS      = 3;
  localparam int          RES_BITS        = 12;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          QUIET_GAP_NS    = 50;
  localparam int          QUIET_GAP_CYC   = (QUIET_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RATE_DIV        = 20;
  // one idle interval pads the frame to RATE_DIV shift clocks
  localparam int          IDLE_CYC_MIN    = (RATE_DIV - FRAME_CLKS) * 2 * SCLK_HALF_CYC;
  localparam int          POWERUP_NS      = 1000;
  localparam int          POWERUP_CYC     = POWERUP_NS / CLK_PERIOD_NS;
  localparam logic [11:0] RESULT_RST      = 12'h000;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_SHIFT = 3'b001,
    ST_GAP   = 3'b011,
    ST_CUT   = 3'b010
  } host_state_t;
endpackage

// File: verilog/shift_link_if.sv
// interface between the frame sequencer and the pin shift engine
`timescale 1ns/1ps
interface shift_link_if;
  logic        start;      // begin a frame
  logic [4:0]  clk_limit;  // shift clocks to give this frame
  logic        busy;       // frame under way
  logic        done;       // pulse: frame finished and frame-select high
  logic [15:0] word;       // bits sampled on rising edges

  modport seq (output start, output clk_limit, input busy, input done, input word);
  modport eng (input start, input clk_limit, output busy, output done, output word);
endinterface

// File: verilog/adc_shift_engine.sv
// pin engine: makes frame-select and shift clock, samples the serial result
`timescale 1ns/1ps
module adc_shift_engine
  import adc_host_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // sequencer side
  shift_link_if.eng lnk,
  // converter pins
  output logic      frame_sel_n,
  output logic      shift_clk,
  input  wire logic serial_result_out
);
  logic [2:0]  sync_ff;
  logic [2:0]  nxt_sync;
  logic        din_ff;
  logic        nxt_din;
  logic        act_ff;
  logic        nxt_act;
  logic [3:0]  half_ff;
  logic [3:0]  nxt_half;
  logic [4:0]  cnt_ff;
  logic [4:0]  nxt_cnt;
  logic        sck_ff;
  logic        nxt_sck;
  logic [15:0] word_ff;
  logic [15:0] nxt_word;
  logic        done_ff;
  logic        nxt_done;

  // three-stage input sampler; second and third must agree
  always_comb
  begin
    nxt_sync = {sync_ff[1:0], serial_result_out};
    nxt_din  = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : din_ff;
  end

  // clock divider, edge count and capture
  always_comb
  begin
    nxt_act  = act_ff;
    nxt_half = half_ff;
    nxt_cnt  = cnt_ff;
    nxt_sck  = sck_ff;
    nxt_word = word_ff;
    nxt_done = 1'b0;
    if (!act_ff)
    begin
      if (lnk.start)
      begin
        nxt_act  = 1'b1; // frame-select falls, device samples input
        nxt_half = 4'h0;
        nxt_cnt  = 5'h00;
        nxt_sck  = 1'b0;
        nxt_word = 16'h0000;
      end
    end
    else if (half_ff == 4'(SCLK_HALF_CYC - 1))
    begin
      nxt_half = 4'h0;
      if (cnt_ff == lnk.clk_limit)
      begin
        nxt_act  = 1'b0; // frame-select rises; early rise cuts word or shuts down
        nxt_done = 1'b1;
      end
      else if (!sck_ff)
      begin
        nxt_sck  = 1'b1; // rising edge: sample the bit settled since the fall
        nxt_word = {word_ff[14:0], nxt_din}; // filtered bit; din_ff itself lags a clock
      end
      else
      begin
        nxt_sck = 1'b0; // falling edge: device shifts next bit
        nxt_cnt = cnt_ff + 5'h01;
      end
    end
    else
      nxt_half = half_ff + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_ff <= 3'h0;
      din_ff  <= 1'b0;
      act_ff  <= 1'b0;
      half_ff <= 4'h0;
      cnt_ff  <= 5'h00;
      sck_ff  <= 1'b0;
      word_ff <= 16'h0000;
      done_ff <= 1'b0;
    end
    else
    begin
      sync_ff <= nxt_sync;
      din_ff  <= nxt_din;
      act_ff  <= nxt_act;
      half_ff <= nxt_half;
      cnt_ff  <= nxt_cnt;
      sck_ff  <= nxt_sck;
      word_ff <= nxt_word;
      done_ff <= nxt_done;
    end
  end

  assign frame_sel_n = ~act_ff;
  assign shift_clk   = sck_ff;
  assign lnk.busy    = act_ff;
  assign lnk.done    = done_ff;
  assign lnk.word    = word_ff;

  // shift clock only moves inside a frame
  chk_clk_in_frame : assert property (@(posedge clk) disable iff (rst)
    !act_ff |-> !sck_ff) else $error("shift clock high outside frame");
  // a full frame gives exactly sixteen falling edges and ends with the clock low
  chk_full_count : assert property (@(posedge clk) disable iff (rst)
    (nxt_done && lnk.clk_limit == 5'(FRAME_CLKS)) |-> (cnt_ff == 5'(FRAME_CLKS) && !sck_ff))
    else $error("full frame edge count wrong");
endmodule

// File: tb/adc_dev_model.sv
// behavioural model of the serial 12-bit converter at the host's pins
`timescale 1ns/1ps
module adc_dev_model
(
  // converter pins
  input  wire logic        frame_sel_n,
  input  wire logic        shift_clk,
  output logic             serial_result_out,
  // bench side
  input  wire logic [11:0] code,
  output logic             asleep,
  output int               last_rises,
  output int               gap_errs
);
  logic [15:0] word_ff;
  logic        drive_ff;
  int          falls;
  int          rises;
  realtime     t_end;

  // power-on mode is unknown, so start asleep: the host must run a dummy frame
  initial
  begin
    asleep = 1'b1;
    drive_ff = 1'b0;
    word_ff = 16'h0000;
    serial_result_out = 1'b1;
    falls = 0;
    rises = 0;
    gap_errs = 0;
    last_rises = 0;
    t_end = -1000.0;
  end

  //----------------------------------------------------------------------------
  // frame start: hold the input, leave high impedance
  //----------------------------------------------------------------------------
  always @(negedge frame_sel_n)
  begin
    if ($realtime - t_end < 50.0)
      gap_errs++;
    // a frame begun while asleep gives garbage, not the code
    word_ff = {4'h0, asleep ? ~code : code};
    drive_ff = 1'b1;
    serial_result_out = word_ff[15];
    falls = 0;
    rises = 0;
  end

  // bits change on falling edges; float after the 16th
  always @(negedge shift_clk)
  begin
    if (frame_sel_n === 1'b0)
    begin
      falls++;
      word_ff = {word_ff[14:0], 1'b0};
      if (falls >= 16)
        drive_ff = 1'b0;
      // a released line shows the inverse of its last level
      serial_result_out = drive_ff ? word_ff[15] : ~serial_result_out;
    end
  end

  // track resumes at rise 13; only counted here
  always @(posedge shift_clk)
  begin
    if (frame_sel_n === 1'b0)
      rises++;
  end

  // frame end: float, shutdown before fall ten, abort before sixteen
  always @(posedge frame_sel_n)
  begin
    if (drive_ff)
      serial_result_out = ~serial_result_out;
    drive_ff = 1'b0;
    last_rises = rises;
    t_end = $realtime;
    asleep = (falls < 10);
  end
endmodule

// File: tb/adc_host_tb.sv
// self-checking bench for the serial converter host controller
`timescale 1ns/1ps
module adc_host_tb;
  import adc_host_pkg::*;
  logic        clk;
  logic        rst;
  logic        conv_req;
  logic        low_power;
  logic        conv_ready;
  logic [11:0] result;
  logic        result_valid;
  logic        powered_down;
  logic        frame_sel_n;
  logic        shift_clk;
  logic        serial_result_out;
  logic [11:0] code;
  logic        asleep;
  logic [31:0] rnd;
  int          last_rises;
  int          gap_errs;
  int          failures;
  int          tests_run;
  int          seed;
  int          vcount;

  adc_host DUT (.clk(clk), .rst(rst), .conv_req(conv_req), .low_power(low_power),
    .conv_ready(conv_ready), .result(result), .result_valid(result_valid),
    .powered_down(powered_down), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
    .serial_result_out(serial_result_out));

  adc_dev_model dev (.frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
    .serial_result_out(serial_result_out), .code(code), .asleep(asleep),
    .last_rises(last_rises), .gap_errs(gap_errs));

  //----------------------------------------------------------------------------
  // clock, result counter, watchdog
  //----------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // count valid pulses mid-cycle, away from the edge that moves them
  always @(negedge clk)
  begin
    if (result_valid === 1'b1)
      vcount++;
  end

  // 16 frames of about 170 cycles each; the 50000-cycle limit, some eighteen times that, is a hang
  initial
  begin
    #2000000;
    failures++;
    test_done();
  end

  task automatic test_done();
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_bit(input logic a, input logic e);
    tests_run++;
    if (a !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, a, e);
    end
  endtask

  task automatic check_code(input logic [11:0] a, input logic [11:0] e);
    tests_run++;
    if (a !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t code %h expected %h", $time, a, e);
    end
  endtask

  task automatic check_int(input int a, input int e);
    tests_run++;
    if (a != e)
    begin
      failures++;
      $display("CHECK FAILED %0t count %0d expected %0d", $time, a, e);
    end
  endtask

  // wait for idle, request one frame, then wait for idle again
  task automatic conv(input logic [11:0] c, input bit dummy);
    int n;
    int v0;
    code = c;
    n = 0;
    while (conv_ready !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check_bit(conv_ready, 1'b1);
    v0 = vcount;
    conv_req = 1'b1;
    @(negedge clk);
    conv_req = 1'b0;
    @(negedge clk);
    check_bit(frame_sel_n, 1'b0);
    n = 0;
    while (conv_ready !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check_bit(conv_ready, 1'b1);
    check_int(vcount - v0, dummy ? 0 : 1);
    check_int(last_rises, FRAME_CLKS);
    check_int(gap_errs, 0);
    if (!dummy)
      check_code(result, c);
  endtask

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    int n;
    logic [11:0] corner [4];
    corner = '{12'h000, 12'hFFF, 12'h800, 12'h001};
    seed = 32'h9EEF624B;
    rst = 1'b1;
    conv_req = 1'b0;
    low_power = 1'b0;
    code = 12'h000;
    failures = 0;
    tests_run = 0;
    vcount = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check_code(result, RESULT_RST);
    check_bit(frame_sel_n, 1'b1);
    conv(12'h5A5, 1'b1);
    check_bit(asleep, 1'b0);
    foreach (corner[i])
      conv(corner[i], 1'b0);
    repeat (8)
    begin
      rnd = $random(seed);
      conv(rnd[11:0], 1'b0);
    end
    // shutdown frame: cut after two shift clocks
    low_power = 1'b1;
    n = 0;
    while (powered_down !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check_bit(powered_down, 1'b1);
    check_bit(asleep, 1'b1);
    check_int(last_rises, SD_CUT_CLKS);
    repeat (50) @(negedge clk);
    check_bit(conv_ready, 1'b0);
    check_bit(frame_sel_n, 1'b1);
    low_power = 1'b0;
    rnd = $random(seed);
    conv(rnd[11:0], 1'b1);
    rnd = $random(seed);
    conv(rnd[11:0], 1'b0);
    check_bit(asleep, 1'b0);
    check_bit(powered_down, 1'b0);
    test_done();
  end
endmodule
